//--- node_cfg_pkg.sv
package node_cfg_pkg;
  localparam logic [7:0] ADDR_IDENTITY   = 8'h00;
  localparam logic [7:0] ADDR_CAPABILITY = 8'h01;
  localparam logic [7:0] ADDR_PROTECT    = 8'h04;
  localparam logic [7:0] ADDR_NODE_ID    = 8'h05;
  localparam logic [7:0] ADDR_PLL        = 8'h06;
  localparam logic [7:0] ADDR_SW_RATIO   = 8'h07;
  localparam logic [7:0] ADDR_REF_RATIO  = 8'h08;
  localparam logic [7:0] ADDR_JTAG_ID    = 8'h09;
  localparam logic [7:0] ADDR_USER_CODE  = 8'h0a;
  localparam logic [7:0] ADDR_DIRS_LOW   = 8'h0c;
  localparam logic [7:0] ADDR_DIRS_HIGH  = 8'h0d;
  localparam logic [7:0] ADDR_DBG_TILE0  = 8'h10;
  localparam logic [7:0] ADDR_DBG_TILE1  = 8'h11;
  localparam logic [7:0] ADDR_DBG_ORIGIN = 8'h1f;

  localparam int PROT_LOCK_BIT   = 31;
  localparam int PROT_PLL_BIT    = 8;
  localparam int PROT_HDR_BIT    = 0;
  localparam int PLL_NORST_BIT   = 31;
  localparam int PLL_NOWAIT_BIT  = 30;
  localparam int PLL_BYPASS_BIT  = 29;
  localparam int PLL_JTAGBT_BIT  = 28;
  localparam int DBG_REQ_EN_BIT  = 1;
  localparam int DBG_DRV_EN_BIT  = 0;
  localparam int ORIGIN_PIN_BIT  = 4;
  localparam int ORIGIN_C1_BIT   = 1;
  localparam int ORIGIN_C0_BIT   = 0;

  // Writable bits of the PLL word: flags 31:28, OD 25:23, F 20:8, R 6:0.
  localparam logic [31:0] PLL_WMASK      = 32'hf39fff7f;
  localparam logic [31:0] PROT_WMASK     = 32'h80000101;
  localparam logic [31:0] PLL_RESET      = 32'h00000000;
  localparam logic [15:0] NODE_ID_RESET  = 16'h0000;
  localparam logic [15:0] SW_RATIO_RESET = 16'h0000;
  localparam logic [15:0] REF_RATIO_RESET = 16'h0003;
  localparam logic [31:0] DIRS_RESET     = 32'h00000000;
endpackage

//--- node_cfg_regs.sv
`timescale 1ns/10ps
`default_nettype none
module node_cfg_regs #(
  parameter logic [7:0]  SWITCH_REVISION = 8'h01, // Arbitrary value.
  parameter logic [7:0]  SWITCH_VERSION  = 8'h02, // Arbitrary value.
  parameter logic [7:0]  LINK_COUNT      = 8'h08,
  parameter logic [7:0]  SWITCH_CORES    = 8'h02,
  parameter logic [7:0]  DEVICE_CORES    = 8'h02,
  parameter logic [31:0] JTAG_DEVICE_ID  = 32'h00000001 // Arbitrary value.
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [31:0] i_cfg_wdata,
  output var  logic [31:0] o_cfg_rdata,
  output var  logic        o_cfg_rvalid,
  input  wire logic [7:0]  i_boot_control_pins,
  input  wire logic [13:0] i_otp_user_code,
  input  wire logic [17:0] i_metal_id_code,
  input  wire logic [15:0] i_pkt_dest,
  output var  logic [3:0]  o_route_dir,
  output var  logic        o_route_local,
  output var  logic        o_header_one_byte,
  output var  logic [15:0] o_node_id,
  output var  logic [31:0] o_pll_settings,
  output var  logic        o_pll_bypass,
  output var  logic        o_boot_from_jtag,
  output var  logic        o_pll_skip_relock,
  output var  logic        o_tile_reset,
  output var  logic        o_chip_reset,
  output var  logic [15:0] o_switch_clock_ratio,
  output var  logic [15:0] o_reference_clock_ratio,
  input  wire logic [1:0]  i_core_halted_flag,
  input  wire logic        i_debug_pin_n,
  output var  logic        o_shared_debug_line,
  output var  logic [1:0]  o_core_debug_req
);
  typedef struct packed {
    logic        boot_taken;
    logic [7:0]  boot_pins;
    logic [31:0] protect;
    logic [15:0] node_id;
    logic [31:0] pll;
    logic [15:0] sw_ratio;
    logic [15:0] ref_ratio;
    logic [31:0] dirs_low;
    logic [31:0] dirs_high;
    logic [1:0]  dbg_cfg0;
    logic [1:0]  dbg_cfg1;
    logic [4:0]  origin;
    logic [2:0]  pin_sync;
    logic        pin_level;
    logic [1:0]  halt_prev;
    logic        line_prev;
    logic [31:0] rdata;
    logic        rvalid;
    logic        tile_rst;
    logic        chip_rst;
    logic [3:0]  route_dir;
    logic        route_local;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic [15:0] mismatch;
  logic [3:0]  msb_pos;
  logic [1:0]  core_drive;
  logic        line_level;
  logic [31:0] rd_mux;
  logic        sw_ok;

  // Ranked route lookup: the highest set mismatch bit wins.
  always_comb begin
    mismatch = i_pkt_dest ^ s_q.node_id;
    msb_pos  = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (mismatch[i]) begin
        msb_pos = 4'(i);
      end
    end
  end

  assign core_drive[0] = s_q.dbg_cfg0[node_cfg_pkg::DBG_DRV_EN_BIT] & i_core_halted_flag[0];
  assign core_drive[1] = s_q.dbg_cfg1[node_cfg_pkg::DBG_DRV_EN_BIT] & i_core_halted_flag[1];
  assign line_level    = s_q.pin_level | (|core_drive);
  assign sw_ok         = ~s_q.protect[node_cfg_pkg::PROT_LOCK_BIT];

  always_comb begin
    rd_mux = 32'h00000000;
    case (i_cfg_addr)
      node_cfg_pkg::ADDR_IDENTITY:   rd_mux = {8'h00, s_q.boot_pins, SWITCH_REVISION,
                                               SWITCH_VERSION};
      node_cfg_pkg::ADDR_CAPABILITY: rd_mux = {8'h00, LINK_COUNT, SWITCH_CORES,
                                               DEVICE_CORES};
      node_cfg_pkg::ADDR_PROTECT:    rd_mux = s_q.protect;
      node_cfg_pkg::ADDR_NODE_ID:    rd_mux = {16'h0000, s_q.node_id};
      node_cfg_pkg::ADDR_PLL:        rd_mux = s_q.pll;
      node_cfg_pkg::ADDR_SW_RATIO:   rd_mux = {16'h0000, s_q.sw_ratio};
      node_cfg_pkg::ADDR_REF_RATIO:  rd_mux = {16'h0000, s_q.ref_ratio};
      node_cfg_pkg::ADDR_JTAG_ID:    rd_mux = JTAG_DEVICE_ID;
      node_cfg_pkg::ADDR_USER_CODE:  rd_mux = {i_otp_user_code, i_metal_id_code};
      node_cfg_pkg::ADDR_DIRS_LOW:   rd_mux = s_q.dirs_low;
      node_cfg_pkg::ADDR_DIRS_HIGH:  rd_mux = s_q.dirs_high;
      node_cfg_pkg::ADDR_DBG_TILE0:  rd_mux = {30'h0, s_q.dbg_cfg0};
      node_cfg_pkg::ADDR_DBG_TILE1:  rd_mux = {30'h0, s_q.dbg_cfg1};
      node_cfg_pkg::ADDR_DBG_ORIGIN: rd_mux = {27'h0, s_q.origin};
      default:                       rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.tile_rst = 1'b0;
    s_d.chip_rst = 1'b0;
    s_d.rvalid   = i_cfg_rd;
    if (i_cfg_rd) begin
      s_d.rdata = rd_mux;
    end

    // Pins are held static around reset, so the first clocked sample is taken as the strap.
    if (!s_q.boot_taken) begin
      s_d.boot_pins  = i_boot_control_pins;
      s_d.boot_taken = 1'b1;
    end

    // Debug pin is asynchronous: three stages, a change counts once the last two agree.
    s_d.pin_sync = {s_q.pin_sync[1:0], ~i_debug_pin_n};
    if (s_q.pin_sync[2] == s_q.pin_sync[1]) begin
      s_d.pin_level = s_q.pin_sync[2];
    end
    s_d.halt_prev = core_drive;
    s_d.line_prev = line_level;
    // A new rising edge of the shared line names its cause and clears the rest.
    if (line_level && !s_q.line_prev) begin
      s_d.origin = 5'h00;
      if (core_drive[0] && !s_q.halt_prev[0]) begin
        s_d.origin[node_cfg_pkg::ORIGIN_C0_BIT] = 1'b1;
      end else if (core_drive[1] && !s_q.halt_prev[1]) begin
        s_d.origin[node_cfg_pkg::ORIGIN_C1_BIT] = 1'b1;
      end else begin
        s_d.origin[node_cfg_pkg::ORIGIN_PIN_BIT] = 1'b1;
      end
    end

    // Hardware recording wins over a software write in the same cycle.
    if (i_cfg_wr && i_cfg_addr == node_cfg_pkg::ADDR_DBG_ORIGIN &&
        !(line_level && !s_q.line_prev)) begin
      s_d.origin = {i_cfg_wdata[4], 2'b00, i_cfg_wdata[1:0]};
    end

    // The protect register itself stays writable so a lock can be lifted.
    if (i_cfg_wr) begin
      case (i_cfg_addr)
        node_cfg_pkg::ADDR_PROTECT: s_d.protect = i_cfg_wdata & node_cfg_pkg::PROT_WMASK;
        node_cfg_pkg::ADDR_NODE_ID: if (sw_ok) s_d.node_id = i_cfg_wdata[15:0];
        node_cfg_pkg::ADDR_PLL: begin
          if (sw_ok && !s_q.protect[node_cfg_pkg::PROT_PLL_BIT]) begin
            s_d.pll      = i_cfg_wdata & node_cfg_pkg::PLL_WMASK;
            s_d.tile_rst = 1'b1;
            s_d.chip_rst = ~i_cfg_wdata[node_cfg_pkg::PLL_NORST_BIT];
          end
        end
        node_cfg_pkg::ADDR_SW_RATIO:  if (sw_ok) s_d.sw_ratio = i_cfg_wdata[15:0];
        node_cfg_pkg::ADDR_REF_RATIO: if (sw_ok) s_d.ref_ratio = i_cfg_wdata[15:0];
        node_cfg_pkg::ADDR_DIRS_LOW:  if (sw_ok) s_d.dirs_low = i_cfg_wdata;
        node_cfg_pkg::ADDR_DIRS_HIGH: if (sw_ok) s_d.dirs_high = i_cfg_wdata;
        node_cfg_pkg::ADDR_DBG_TILE0: if (sw_ok) s_d.dbg_cfg0 = i_cfg_wdata[1:0];
        node_cfg_pkg::ADDR_DBG_TILE1: if (sw_ok) s_d.dbg_cfg1 = i_cfg_wdata[1:0];
        default: ;
      endcase
    end

    s_d.route_local = (mismatch == 16'h0000);
    if (msb_pos[3]) begin
      s_d.route_dir = s_q.dirs_high[{msb_pos[2:0], 2'b00} +: 4];
    end else begin
      s_d.route_dir = s_q.dirs_low[{msb_pos[2:0], 2'b00} +: 4];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q           <= '0;
      s_q.protect   <= 32'h00000000;
      s_q.node_id   <= node_cfg_pkg::NODE_ID_RESET;
      s_q.pll       <= node_cfg_pkg::PLL_RESET;
      s_q.sw_ratio  <= node_cfg_pkg::SW_RATIO_RESET;
      s_q.ref_ratio <= node_cfg_pkg::REF_RATIO_RESET;
      s_q.dirs_low  <= node_cfg_pkg::DIRS_RESET;
      s_q.dirs_high <= node_cfg_pkg::DIRS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_cfg_rdata             = s_q.rdata;
  assign o_cfg_rvalid            = s_q.rvalid;
  assign o_route_dir             = s_q.route_dir;
  assign o_route_local           = s_q.route_local;
  assign o_header_one_byte       = s_q.protect[node_cfg_pkg::PROT_HDR_BIT];
  assign o_node_id               = s_q.node_id;
  assign o_pll_settings          = s_q.pll;
  assign o_pll_bypass            = s_q.pll[node_cfg_pkg::PLL_BYPASS_BIT];
  assign o_boot_from_jtag        = s_q.pll[node_cfg_pkg::PLL_JTAGBT_BIT];
  assign o_pll_skip_relock       = s_q.pll[node_cfg_pkg::PLL_NOWAIT_BIT];
  assign o_tile_reset            = s_q.tile_rst;
  assign o_chip_reset            = s_q.chip_rst;
  assign o_switch_clock_ratio    = s_q.sw_ratio;
  assign o_reference_clock_ratio = s_q.ref_ratio;
  assign o_shared_debug_line     = line_level;
  assign o_core_debug_req[0] = line_level & s_q.dbg_cfg0[node_cfg_pkg::DBG_REQ_EN_BIT];
  assign o_core_debug_req[1] = line_level & s_q.dbg_cfg1[node_cfg_pkg::DBG_REQ_EN_BIT];
endmodule
`default_nettype wire

//--- node_cfg_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
module node_cfg_checker (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_cfg_wr,
  input wire logic        i_cfg_rd,
  input wire logic [7:0]  i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic        o_cfg_rvalid,
  input wire logic        o_tile_reset,
  input wire logic        o_chip_reset,
  input wire logic [31:0] o_pll_settings,
  input wire logic        o_pll_bypass,
  input wire logic        o_boot_from_jtag,
  input wire logic        o_pll_skip_relock,
  input wire logic [15:0] i_pkt_dest,
  input wire logic [15:0] o_node_id,
  input wire logic        o_route_local,
  input wire logic [1:0]  o_core_debug_req,
  input wire logic        o_shared_debug_line,
  input wire logic [15:0] o_reference_clock_ratio,
  input wire logic        o_header_one_byte
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  chk_read_answer: assert property (i_cfg_rd |=> o_cfg_rvalid)
    else $error("read request got no answer");
  chk_tile_cause: assert property (o_tile_reset |->
    $past(i_cfg_wr) && $past(i_cfg_addr) == node_cfg_pkg::ADDR_PLL)
    else $error("tile reset without a PLL write");
  chk_chip_reset: assert property ((o_tile_reset || o_chip_reset) |->
    o_tile_reset && o_chip_reset == !$past(i_cfg_wdata[31]))
    else $error("chip reset does not follow bit 31");
  chk_pll_fields: assert property (o_tile_reset |->
    o_pll_settings == ($past(i_cfg_wdata) & node_cfg_pkg::PLL_WMASK))
    else $error("PLL word not stored through its mask");
  chk_pll_flags: assert property (o_tile_reset |->
    o_pll_bypass == $past(i_cfg_wdata[29]) && o_boot_from_jtag == $past(i_cfg_wdata[28]))
    else $error("bypass or boot flag wrong");
  chk_relock_skip: assert property (o_tile_reset |->
    o_pll_skip_relock == $past(i_cfg_wdata[30]))
    else $error("relock skip flag wrong");
  chk_route_local: assert property (!$past(i_rst) |->
    o_route_local == ($past(i_pkt_dest) == $past(o_node_id)))
    else $error("local route flag wrong");
  chk_debug_req: assert property (o_core_debug_req != 2'b00 |-> o_shared_debug_line)
    else $error("debug request without shared line");
  chk_ref_ratio: assert property ($changed(o_reference_clock_ratio) |->
    $past(i_cfg_wr) && $past(i_cfg_addr) == node_cfg_pkg::ADDR_REF_RATIO
    && o_reference_clock_ratio == $past(i_cfg_wdata[15:0]))
    else $error("reference ratio changed without a write");
  chk_header_mode: assert property ($changed(o_header_one_byte) |->
    $past(i_cfg_wr) && $past(i_cfg_addr) == node_cfg_pkg::ADDR_PROTECT
    && o_header_one_byte == $past(i_cfg_wdata[0]))
    else $error("header mode changed without a write");
endmodule
`default_nettype wire

//--- node_cfg_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module node_cfg_regs_tb;
  logic        i_clk = 1'b0, i_rst = 1'b1, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0;
  logic        i_debug_pin_n = 1'b1, o_cfg_rvalid, o_route_local, o_header_one_byte;
  logic        o_pll_bypass, o_boot_from_jtag, o_pll_skip_relock, o_tile_reset;
  logic        o_chip_reset, o_shared_debug_line;
  logic [1:0]  i_core_halted_flag = 2'b00, o_core_debug_req;
  logic [3:0]  o_route_dir;
  logic [7:0]  i_cfg_addr = 8'h00, i_boot_control_pins, boot;
  logic [13:0] i_otp_user_code;
  logic [17:0] i_metal_id_code;
  logic [15:0] i_pkt_dest = 16'h0000, o_node_id, o_switch_clock_ratio, o_reference_clock_ratio;
  logic [31:0] i_cfg_wdata = 32'h0, o_cfg_rdata, o_pll_settings, d, ident, pll_v;
  logic [63:0] dirs;
  logic [15:0] nid;
  logic [31:0] exp_q[$];
  logic [7:0]  wa [10] = '{8'h05, 8'h07, 8'h08, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h00, 8'h02, 8'h06};
  logic [31:0] wm [10];
  int          n_fail = 0, total_checks = 0, cycles = 0;
  int          seed = 32'h576f4b77;
  node_cfg_regs dut (.*);
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access per call; the release lands a full cycle before the next request.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(negedge i_clk);
    i_cfg_wr = w;
    i_cfg_rd = !w;
    i_cfg_addr = a;
    i_cfg_wdata = v;
    if (!w) exp_q.push_back(v);
    @(negedge i_clk);
    i_cfg_wr = 1'b0;
    i_cfg_rd = 1'b0;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (o_cfg_rvalid === 1'b1) check(o_cfg_rdata, exp_q.pop_front());
    if (cycles > 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    boot = $random(seed);
    i_boot_control_pins = boot;
    i_otp_user_code = $random(seed);
    i_metal_id_code = $random(seed);
    ident = {8'h00, boot, 8'h01, 8'h02};
    wm = '{32'hffff, 32'hffff, 32'hffff, '1, '1, 32'h3, 32'h3, 32'h0, 32'h0, 32'hf39fff7f};
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    i_boot_control_pins = ~boot;
    acc(1'b0, 8'h00, ident);
    acc(1'b0, 8'h01, 32'h00080202);
    acc(1'b0, 8'h0a, {i_otp_user_code, i_metal_id_code});
    acc(1'b0, 8'h09, 32'h1);
    for (int k = 0; k < 9; k++) begin
      d = (wa[k] == 8'h00) ? ident : (wa[k] == 8'h08) ? 32'h3 : 32'h0;
      acc(1'b0, wa[k], d);
    end
    acc(1'b0, 8'h04, 32'h0);
    for (int k = 0; k < 10; k++) begin
      d = $random(seed);
      acc(1'b1, wa[k], d);
      if (wa[k] == 8'h05) nid = d[15:0];
      acc(1'b0, wa[k], (wa[k] == 8'h00) ? ident : d & wm[k]);
    end
    pll_v = d & wm[9];
    acc(1'b1, 8'h04, 32'hffffffff);
    acc(1'b0, 8'h04, 32'h80000101);
    check(o_header_one_byte, 1'b1);
    acc(1'b1, 8'h05, 32'h1234);
    acc(1'b1, 8'h06, 32'h0);
    check(o_tile_reset, 1'b0);
    acc(1'b0, 8'h05, {16'h0000, nid});
    acc(1'b1, 8'h04, 32'h100);
    acc(1'b1, 8'h06, 32'h0);
    check(o_tile_reset, 1'b0);
    acc(1'b0, 8'h06, pll_v);
    acc(1'b1, 8'h04, 32'h0);
    d = $random(seed);
    dirs = {$random(seed), $random(seed)};
    acc(1'b1, 8'h05, d);
    acc(1'b1, 8'h0c, dirs[31:0]);
    acc(1'b1, 8'h0d, dirs[63:32]);
    for (int k = 0; k < 16; k++) begin
      @(negedge i_clk);
      i_pkt_dest = d[15:0] ^ (16'h1 << k) ^ (16'($random(seed)) & ((16'h1 << k) - 16'h1));
      @(negedge i_clk);
      check(o_route_dir, dirs[4*k +: 4]);
    end
    acc(1'b1, 8'h10, 32'h3);
    acc(1'b1, 8'h11, 32'h0);
    i_core_halted_flag = 2'b01;
    @(negedge i_clk);
    check({o_shared_debug_line, o_core_debug_req}, 3'b101);
    acc(1'b0, 8'h1f, 32'h1);
    acc(1'b1, 8'h10, 32'h0);
    acc(1'b1, 8'h11, 32'h2);
    i_core_halted_flag = 2'b11;
    @(negedge i_clk);
    check(o_shared_debug_line, 1'b0);
    i_core_halted_flag = 2'b00;
    i_debug_pin_n = 1'b0;
    repeat (6) @(negedge i_clk);
    check({o_shared_debug_line, o_core_debug_req}, 3'b110);
    acc(1'b0, 8'h1f, 32'h10);
    i_debug_pin_n = 1'b1;
    repeat (3) @(negedge i_clk);
    check(exp_q.size(), 32'h0);
    end_of_test();
  end
endmodule
bind node_cfg_regs node_cfg_checker chk (.*);
`default_nettype wire
